/* verilog/lsd_defs.svh */
// Register offsets, field positions and reset values of the sink driver control block.
`ifndef LSD_DEFS_SVH
`define LSD_DEFS_SVH
`define LSD_NUM_DRIVERS 2
`define LSD_DATA_IDX 1
`define LSD_CFG_IDX 1
// Printed offsets 0x0 and 0x1 are not both multiples of four, so they are indices.
`define LSD_OFF_DATA_IDX 4'h0
`define LSD_OFF_CFG_IDX 4'h1
`define LSD_ADDR_DATA 12'h000
`define LSD_ADDR_CFG 12'h004
`define LSD_ADDR_SRC 12'h008
`define LSD_CFG_EN_LSB 0
`define LSD_CFG_OLE_LSB 2
`define LSD_DATA_RESET 2'h0
`define LSD_CFG_RESET 4'h0
`define LSD_SRC_RESET 4'h0
`define LSD_SRC_DATA 2'h0
`define LSD_SRC_TIMER 2'h1
`define LSD_SRC_PWM 2'h2
`endif

/* verilog/lsd_pkg.sv */
// Types shared by the sink driver control block.
`default_nettype none
package lsd_pkg;
   typedef enum logic [1:0] {
      LSD_SEL_DATA = 2'b00,
      LSD_SEL_TIMER = 2'b01,
      LSD_SEL_PWM = 2'b10
   } lsd_source_e;
   typedef struct packed {
      logic [1:0] driverOn;
      logic [1:0] driverEnable;
      logic [1:0] openLoadActive;
   } lsd_drive_s;
   typedef logic [1:0] lsd_pair_t;
endpackage : lsd_pkg
`default_nettype wire

/* verilog/lsd_source_mux.sv */
// Per-driver selection of the live control source.
`default_nettype none
`include "lsd_defs.svh"
module lsd_source_mux
   import lsd_pkg::*;
#(
   parameter int NUM = 2
)(
   input wire logic [NUM-1:0] dataBit,
   input wire logic [NUM-1:0] timerBit,
   input wire logic [NUM-1:0] pwmBit,
   input wire logic [2*NUM-1:0] sourceSel,
   output logic [NUM-1:0] liveLevel
);
   genvar g;
   generate
      for (g = 0; g < NUM; g++)
      begin : gSel
         always_comb
         begin
            case (sourceSel[2*g +: 2])
               `LSD_SRC_TIMER: liveLevel[g] = timerBit[g];
               `LSD_SRC_PWM: liveLevel[g] = pwmBit[g];
               default: liveLevel[g] = dataBit[g];
            endcase
         end
      end
   endgenerate
endmodule : lsd_source_mux
`default_nettype wire

/* verilog/lsd_ctrl.sv */
// APB register bank and drive logic for two low-side sink drivers.
// What this block does
// - Each data bit switches its driver when it is the selected source.
// - Writing one to a selected data bit turns that driver on.
// - With enable zero, reading a data bit returns the stored value.
// - With enable one, reading a data bit returns the live selected source.
// - Entering stop mode clears all data bits.
// - Config bits 3..2 enable open-load detection when enabled and not driven.
// - Config bits 1..0 enable each driver's bias.
// - Config register is readable and writable at any time.
// - In stop both drivers are disabled and off; re-enabled after stop.
`default_nettype none
`include "lsd_defs.svh"
module lsd_ctrl
   import lsd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stopMode,
   input wire logic [1:0] timerCompareOutput,
   input wire logic [1:0] pwmOutput,
   output lsd_drive_s drive
);
   logic [1:0] sinkDriveData;
   logic [3:0] sinkDriverConfig;
   logic [3:0] sourceSelect;
   logic [1:0] stopSync;
   logic [1:0] timerSync0, timerSync;
   logic [1:0] pwmSync0, pwmSync;
   logic stopPrev;
   logic [1:0] liveLevel;
   logic [1:0] readData;
   logic setupPhase, wrData, wrCfg, wrSrc, hitMapped;
   logic [31:0] next_prdata;

   // Stop and the routed sources come from other logic domains; synchronise them.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stopSync <= 2'h0;
         timerSync0 <= 2'h0;
         timerSync <= 2'h0;
         pwmSync0 <= 2'h0;
         pwmSync <= 2'h0;
         stopPrev <= 1'b0;
      end
      else
      begin
         stopSync <= {stopSync[0], stopMode};
         timerSync0 <= timerCompareOutput;
         timerSync <= timerSync0;
         pwmSync0 <= pwmOutput;
         pwmSync <= pwmSync0;
         stopPrev <= stopSync[1];
      end
   end

   // The access phase is answered in its first cycle, so pready is the setup cycle delayed.
   assign setupPhase = psel && !penable;
   assign wrData = psel && penable && pready && pwrite && paddr == `LSD_ADDR_DATA;
   assign wrCfg = psel && penable && pready && pwrite && paddr == `LSD_ADDR_CFG;
   assign wrSrc = psel && penable && pready && pwrite && paddr == `LSD_ADDR_SRC;
   assign hitMapped = paddr == `LSD_ADDR_DATA || paddr == `LSD_ADDR_CFG ||
                      paddr == `LSD_ADDR_SRC;

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         sinkDriveData <= `LSD_DATA_RESET;
      else if (stopSync[1] && !stopPrev)
         sinkDriveData <= `LSD_DATA_RESET;
      else if (wrData)
         sinkDriveData <= pwdata[1:0];
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         sinkDriverConfig <= `LSD_CFG_RESET;
      else if (wrCfg)
         sinkDriverConfig <= pwdata[3:0];
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         sourceSelect <= `LSD_SRC_RESET;
      else if (wrSrc)
         sourceSelect <= pwdata[3:0];
   end

   lsd_source_mux #(
      .NUM(2)
   ) uMux (
      .dataBit(sinkDriveData),
      .timerBit(timerSync),
      .pwmBit(pwmSync),
      .sourceSel(sourceSelect),
      .liveLevel(liveLevel)
   );

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gRead
         assign readData[g] = sinkDriverConfig[`LSD_CFG_EN_LSB + g] ?
                              liveLevel[g] : sinkDriveData[g];
      end
   endgenerate

   always_comb
   begin
      next_prdata = 32'h0000_0000;
      case (paddr)
         `LSD_ADDR_DATA: next_prdata = {30'h0, readData};
         `LSD_ADDR_CFG: next_prdata = {28'h0, sinkDriverConfig};
         `LSD_ADDR_SRC: next_prdata = {28'h0, sourceSelect};
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setupPhase;
         pslverr <= setupPhase && !hitMapped;
         prdata <= setupPhase && !pwrite ? next_prdata : 32'h0000_0000;
      end
   end

   // Stop overrides everything; run-time selection resumes on its own when stop ends.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         drive <= '0;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            drive.driverEnable[i] <= sinkDriverConfig[`LSD_CFG_EN_LSB + i] &&
                                     !stopSync[1];
            drive.driverOn[i] <= sinkDriverConfig[`LSD_CFG_EN_LSB + i] &&
                                 !stopSync[1] && liveLevel[i];
            drive.openLoadActive[i] <= sinkDriverConfig[`LSD_CFG_OLE_LSB + i] &&
                                       sinkDriverConfig[`LSD_CFG_EN_LSB + i] &&
                                       !stopSync[1] && !liveLevel[i];
         end
      end
   end

   // bind software; the driver simply follows its inputs.

   driver_follows_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sinkDriverConfig[0] && !stopSync[1] && liveLevel[0] |=> drive.driverOn[0])
      else $error("Driver 0 did not turn on.");
   data_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wrData && !(stopSync[1] && !stopPrev) |=> sinkDriveData == $past(pwdata[1:0]))
      else $error("Data write lost.");
   stored_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      setupPhase && !pwrite && paddr == `LSD_ADDR_DATA && !sinkDriverConfig[0]
      |=> prdata[0] == $past(sinkDriveData[0]))
      else $error("Stored read wrong.");
   live_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      setupPhase && !pwrite && paddr == `LSD_ADDR_DATA && sinkDriverConfig[1]
      |=> prdata[1] == $past(liveLevel[1]))
      else $error("Live read wrong.");
   stop_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      stopSync[1] && !stopPrev |=> sinkDriveData == 2'h0)
      else $error("Stop did not clear data.");
   open_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      drive.openLoadActive[0] |-> !drive.driverOn[0] && drive.driverEnable[0])
      else $error("Open-load active while driven.");
   enable_bias_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !sinkDriverConfig[1] |=> !drive.driverEnable[1] && !drive.driverOn[1])
      else $error("Disabled driver active.");
   config_rw_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wrCfg |=> sinkDriverConfig == $past(pwdata[3:0]))
      else $error("Config write lost.");
   stop_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      stopSync[1] |=> drive == '0)
      else $error("Driver active in stop.");
   upper_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      pready && paddr == `LSD_ADDR_DATA |-> prdata[31:2] == 30'h0)
      else $error("Upper data bits not zero.");

   // A config read is a setup cycle naming the word; the answer must follow at once.
   sequence config_read_setup;
      setupPhase && !pwrite && paddr == `LSD_ADDR_CFG;
   endsequence

   config_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      config_read_setup |=> pready && prdata == {28'h0, $past(sinkDriverConfig)})
      else $error("Config read wrong.");

   // Leaving stop hands an enabled driver its bias back without software help.
   sequence stop_left_enabled;
      !stopSync[1] && sinkDriverConfig[1];
   endsequence

   driver_reenable_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      stop_left_enabled |=> drive.driverEnable[1])
      else $error("Driver not re-enabled after stop.");
endmodule : lsd_ctrl
`default_nettype wire

/* verif/test_low_side_driver_control_regs.sv */
// Self-checking testbench for the sink driver control block.
`default_nettype none
module test_low_side_driver_control_regs
   import lsd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] wd;
      logic [31:0] rdExp;
      logic errExp;
   } lsd_row_s;
   logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, stopMode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [1:0] timerCompareOutput, pwmOutput;
   logic err;
   lsd_drive_s drive;
   int fails = 0;
   int checksDone = 0;
   // Settling interval software allows after enabling a driver; a plain default.
   localparam int DRIVER_SETTLE_WAIT = 8;
   // Upper data bits must be dropped, and an unmapped word must be refused.
   lsd_row_s rows [4] = '{
      '{12'h004, 32'h0000000F, 32'h0000000F, 1'b0},
      '{12'h000, 32'hFFFFFFFF, 32'h00000003, 1'b0},
      '{12'h00C, 32'h00000005, 32'h00000000, 1'b1},
      '{12'h000, 32'h00000001, 32'h00000001, 1'b0}};

   lsd_ctrl u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stopMode(stopMode), .timerCompareOutput(timerCompareOutput),
      .pwmOutput(pwmOutput), .drive(drive));

   always #10 clk_sys = ~clk_sys;

   task automatic test_done;
      if (fails == 0 && checksDone > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // The answer stands for one cycle only: read data and the error flag are taken
   // at the rising edge that samples pready high, before that edge's updates land.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         fails++;
         test_done();
      end
      rdata = prdata;
      err = pslverr;
      @(posedge clk_sys);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb

   initial
   begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      stopMode = 1'b0;
      timerCompareOutput = 2'h0;
      pwmOutput = 2'h0;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      check("drive", 32'(drive), 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      check("data", rdata, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      check("config", rdata, 32'h0);
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, rows[i].wd);
         check("werr", 32'(err), 32'(rows[i].errExp));
         repeat (DRIVER_SETTLE_WAIT) @(posedge clk_sys);
         apb(1'b0, rows[i].a, 32'h0);
         check("rd", rdata, rows[i].rdExp);
         check("rerr", 32'(err), 32'(rows[i].errExp));
      end
      check("drive", 32'(drive), 32'h1E);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h008, 32'h1);
      timerCompareOutput <= 2'b01;
      repeat (6) @(posedge clk_sys);
      apb(1'b0, 12'h000, 32'h0);
      check("live", rdata, 32'h1);
      check("drive", 32'(drive), 32'h1E);
      // Stored bit 0 is set while the timer keeps driver 0 off, so stored and live differ.
      timerCompareOutput <= 2'b00;
      repeat (6) @(posedge clk_sys);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h004, 32'hC);
      apb(1'b0, 12'h000, 32'h0);
      check("stored", rdata, 32'h1);
      check("en", 32'(drive.driverEnable), 32'h0);
      apb(1'b1, 12'h008, 32'h9);
      apb(1'b1, 12'h004, 32'h3);
      repeat (DRIVER_SETTLE_WAIT) @(posedge clk_sys);
      timerCompareOutput <= 2'b01;
      pwmOutput <= 2'b10;
      repeat (6) @(posedge clk_sys);
      apb(1'b0, 12'h000, 32'h0);
      check("live", rdata, 32'h3);
      check("drive", 32'(drive), 32'h3C);
      // Data bits are loaded while the PWM source holds both drivers off.
      timerCompareOutput <= 2'b00;
      pwmOutput <= 2'b00;
      repeat (6) @(posedge clk_sys);
      apb(1'b1, 12'h008, 32'hA);
      apb(1'b1, 12'h000, 32'h3);
      stopMode <= 1'b1;
      repeat (6) @(posedge clk_sys);
      check("stop", 32'(drive), 32'h0);
      stopMode <= 1'b0;
      repeat (6) @(posedge clk_sys);
      check("wake", 32'(drive), 32'h0C);
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      check("cleared", rdata, 32'h0);
      check("data off", 32'(drive), 32'h0C);
      apb(1'b1, 12'h004, 32'hF);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      check("reset drive", 32'(drive), 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      check("reset config", rdata, 32'h0);
      test_done();
   end
endmodule : test_low_side_driver_control_regs
`default_nettype wire
